// ==== core/orcm_map.vh ====
// Overview of operation
// RULE_01: status output high while input exceeds threshold
// RULE_02: asserted status holds for minimum pulse length
// RULE_03: channel C/D over-range only in quad mode
// RULE_04: C clock needs config select and PLL enable
// RULE_05: config zero or disabled gives C/D over-range
// RULE_06: C code 1 direct, 2 half, 3 quarter
// RULE_07: C clock runs from reset without programming
// RULE_08: any config pin set gives direct D clock
// RULE_09: D divided clocks only by register override
// RULE_10: D clock only while C clock runs
// RULE_11: power-down stops reference and auxiliary clocks
// RULE_12: system keeps power-down low when clocks needed
// RULE_13: reference repeat runs with PLL enable, no power-down
// RULE_14: PLL enable high enables PLL, low bypasses
// RULE_15: status returns low after pulse and input clear
`ifndef ORCM_MAP_VH
`define ORCM_MAP_VH

// ---------------------------------------------------------------
// register offsets
// ---------------------------------------------------------------
`define ORCM_ADDR_W          4
`define ORCM_DATA_W          16
`define ORCM_OFF_CTRL        4'h0
`define ORCM_OFF_THRESH      4'h1
`define ORCM_OFF_MINPULSE    4'h2
`define ORCM_OFF_STATE       4'h3
`define ORCM_OFF_IRQ_STATUS  4'h4
`define ORCM_OFF_IRQ_MASK    4'h5

// ---------------------------------------------------------------
// control register fields
// ---------------------------------------------------------------
`define ORCM_CTRL_QUAD       0
`define ORCM_CTRL_OVRD_EN    1
`define ORCM_CTRL_SEL_C_LO   2
`define ORCM_CTRL_SEL_C_HI   3
`define ORCM_CTRL_SEL_D_LO   4
`define ORCM_CTRL_SEL_D_HI   5
`define ORCM_CTRL_AUX_DIS    6
`define ORCM_CTRL_W          7

// ---------------------------------------------------------------
// reset values
// ---------------------------------------------------------------
`define ORCM_CTRL_RST        7'h01
`define ORCM_THRESH_RST      12'h700
`define ORCM_MINPULSE_RST    8'h08
`define ORCM_IRQ_MASK_RST    5'h00

// ---------------------------------------------------------------
// widths and encodings
// ---------------------------------------------------------------
`define ORCM_SAMPLE_W        12
`define ORCM_PULSE_W         8
`define ORCM_IRQ_W           5
`define ORCM_IRQ_PD          4
`define ORCM_CLK_OFF         2'h0
`define ORCM_CLK_DIRECT      2'h1
`define ORCM_CLK_DIV2        2'h2
`define ORCM_CLK_DIV4        2'h3

`endif

// ==== core/orcm_pulse.v ====
`timescale 1ns/1ps
`include "orcm_map.vh"

module orcm_pulse (
  // clock and reset
  input  wire                         clk_i,
  input  wire                         resetn_i,
  // settings
  input  wire                         enable_i,
  input  wire [`ORCM_SAMPLE_W-1:0]    thresh_i,
  input  wire [`ORCM_PULSE_W-1:0]     min_pulse_i,
  // sample stream
  input  wire [`ORCM_SAMPLE_W-1:0]    sample_i,
  // status
  output wire                         level_o,
  output wire                         rise_o
);

  // magnitude of a signed sample; full negative maps to 2048 without wrap
  function [`ORCM_SAMPLE_W:0] orcm_mag;
    input [`ORCM_SAMPLE_W-1:0] s;
    begin
      if (s[`ORCM_SAMPLE_W-1]) begin
        orcm_mag = {1'b0, ~s} + {{`ORCM_SAMPLE_W{1'b0}}, 1'b1};
      end else begin
        orcm_mag = {1'b0, s};
      end
    end
  endfunction

  wire                      exceed;
  reg                       out_q;
  reg                       prev_q;
  reg [`ORCM_PULSE_W-1:0]   cnt_q;

  assign exceed = enable_i & (orcm_mag(sample_i) > {1'b0, thresh_i}); // RULE_01

  // stretch: every exceeding sample reloads the hold count
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      out_q <= 1'b0;
      cnt_q <= {`ORCM_PULSE_W{1'b0}};
    end else if (exceed) begin
      out_q <= 1'b1;                          // RULE_01
      cnt_q <= min_pulse_i;                   // RULE_02
    end else if (!enable_i) begin
      out_q <= 1'b0;
      cnt_q <= {`ORCM_PULSE_W{1'b0}};
    end else begin
      out_q <= (cnt_q > {{(`ORCM_PULSE_W-1){1'b0}}, 1'b1}); // RULE_02 RULE_15
      if (cnt_q != {`ORCM_PULSE_W{1'b0}}) begin
        cnt_q <= cnt_q - {{(`ORCM_PULSE_W-1){1'b0}}, 1'b1};
      end
    end
  end

  // edge detect for the event flag
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      prev_q <= 1'b0;
    end else begin
      prev_q <= out_q;
    end
  end

  assign level_o = out_q;
  assign rise_o  = out_q & ~prev_q;

endmodule

// ==== core/orcm_top.v ====
`timescale 1ns/1ps
`include "orcm_map.vh"

module orcm_top (
  // clock and reset
  input  wire                         clk_i,
  input  wire                         resetn_i,
  // register port
  input  wire [`ORCM_ADDR_W-1:0]      reg_addr_i,
  input  wire [`ORCM_DATA_W-1:0]      reg_wdata_i,
  input  wire                         reg_wr_i,
  input  wire                         reg_rd_i,
  output wire [`ORCM_DATA_W-1:0]      reg_rdata_o,
  // converter samples, same clock domain
  input  wire [`ORCM_SAMPLE_W-1:0]    sample_a_i,
  input  wire [`ORCM_SAMPLE_W-1:0]    sample_b_i,
  input  wire [`ORCM_SAMPLE_W-1:0]    sample_c_i,
  input  wire [`ORCM_SAMPLE_W-1:0]    sample_d_i,
  // device pins in
  input  wire [1:0]                   aux_clock_config_pins_i,
  input  wire                         pll_enable_i,
  input  wire                         power_down_in_i,
  input  wire                         ref_clock_in_i,
  // device pins out
  output wire                         overrange_out_a_o,
  output wire                         overrange_out_b_o,
  output wire                         overrange_or_clock_out_c_o,
  output wire                         overrange_or_clock_out_d_o,
  output wire                         reference_clock_repeat_out_o,
  output wire                         pll_active_o,
  output wire                         pll_bypass_o,
  output wire                         powered_down_o,
  // interrupt
  output wire                         irq_o
);

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  reg  [1:0] cfg_s1_q;
  reg  [1:0] cfg_s2_q;
  reg        pll_s1_q;
  reg        pll_s2_q;
  reg        pd_s1_q;
  reg        pd_s2_q;
  reg        ref_s1_q;
  reg        ref_s2_q;

  // two stages on every pin; only the second stage feeds logic
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cfg_s1_q <= 2'h0;
      cfg_s2_q <= 2'h0;
      pll_s1_q <= 1'b0;
      pll_s2_q <= 1'b0;
      pd_s1_q  <= 1'b1;
      pd_s2_q  <= 1'b1;
      ref_s1_q <= 1'b0;
      ref_s2_q <= 1'b0;
    end else begin
      cfg_s1_q <= aux_clock_config_pins_i;
      cfg_s2_q <= cfg_s1_q;
      pll_s1_q <= pll_enable_i;
      pll_s2_q <= pll_s1_q;
      pd_s1_q  <= power_down_in_i;
      pd_s2_q  <= pd_s1_q;
      ref_s1_q <= ref_clock_in_i;
      ref_s2_q <= ref_s1_q;
    end
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  reg  [`ORCM_CTRL_W-1:0]     ctrl_q;
  reg  [`ORCM_SAMPLE_W-1:0]   thresh_q;
  reg  [`ORCM_PULSE_W-1:0]    minpulse_q;
  reg  [`ORCM_IRQ_W-1:0]      irq_stat_q;
  reg  [`ORCM_IRQ_W-1:0]      irq_mask_q;
  reg  [`ORCM_DATA_W-1:0]     rdata_q;
  reg  [`ORCM_DATA_W-1:0]     rdata_d;
  wire [`ORCM_IRQ_W-1:0]      irq_set;
  wire                        wr_ctrl;
  wire                        wr_irq;

  assign wr_ctrl = reg_wr_i & (reg_addr_i == `ORCM_OFF_CTRL);
  assign wr_irq  = reg_wr_i & (reg_addr_i == `ORCM_OFF_IRQ_STATUS);

  // reset values select pins and quad mode, so clocks need no programming
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ctrl_q     <= `ORCM_CTRL_RST;                 // RULE_07
      thresh_q   <= `ORCM_THRESH_RST;
      minpulse_q <= `ORCM_MINPULSE_RST;
      irq_mask_q <= `ORCM_IRQ_MASK_RST;
    end else if (reg_wr_i) begin
      if (wr_ctrl) begin
        ctrl_q <= reg_wdata_i[`ORCM_CTRL_W-1:0];
      end
      if (reg_addr_i == `ORCM_OFF_THRESH) begin
        thresh_q <= reg_wdata_i[`ORCM_SAMPLE_W-1:0];
      end
      if (reg_addr_i == `ORCM_OFF_MINPULSE) begin
        minpulse_q <= reg_wdata_i[`ORCM_PULSE_W-1:0];
      end
      if (reg_addr_i == `ORCM_OFF_IRQ_MASK) begin
        irq_mask_q <= reg_wdata_i[`ORCM_IRQ_W-1:0];
      end
    end
  end

  // sticky events; a new event in the clearing cycle survives
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      irq_stat_q <= {`ORCM_IRQ_W{1'b0}};
    end else begin
      irq_stat_q <= (irq_stat_q & ~(wr_irq ? reg_wdata_i[`ORCM_IRQ_W-1:0]
                                           : {`ORCM_IRQ_W{1'b0}})) | irq_set;
    end
  end

  assign irq_o = |(irq_stat_q & irq_mask_q);

  // ---------------------------------------------------------------
  // clock routing decisions
  // ---------------------------------------------------------------
  wire       quad_mode;
  wire       ovrd_en;
  wire       aux_dis;
  wire [1:0] sel_c;
  wire [1:0] sel_d;
  wire       clocks_on;
  wire       clk_c_on;
  wire       clk_d_on;

  assign quad_mode = ctrl_q[`ORCM_CTRL_QUAD];
  assign ovrd_en   = ctrl_q[`ORCM_CTRL_OVRD_EN];
  assign aux_dis   = ctrl_q[`ORCM_CTRL_AUX_DIS];

  // pins choose unless software overrides
  assign sel_c = ovrd_en ? ctrl_q[`ORCM_CTRL_SEL_C_HI:`ORCM_CTRL_SEL_C_LO]
                         : cfg_s2_q;                               // RULE_04 RULE_06
  // pins give D only a direct copy; divided D needs the override
  assign sel_d = ovrd_en ? ctrl_q[`ORCM_CTRL_SEL_D_HI:`ORCM_CTRL_SEL_D_LO]
                         : ((cfg_s2_q != `ORCM_CLK_OFF) ? `ORCM_CLK_DIRECT
                                                        : `ORCM_CLK_OFF); // RULE_08 RULE_09

  assign clocks_on = pll_s2_q & ~pd_s2_q;                          // RULE_11 RULE_13
  assign clk_c_on  = clocks_on & ~aux_dis & (sel_c != `ORCM_CLK_OFF);   // RULE_04 RULE_05
  assign clk_d_on  = clk_c_on & (sel_d != `ORCM_CLK_OFF);          // RULE_10

  // ---------------------------------------------------------------
  // reference repeat and dividers
  // ---------------------------------------------------------------
  reg        ref_prev_q;
  reg  [1:0] div_q;
  reg        ref_out_q;
  reg        out_c_q;
  reg        out_d_q;
  wire       ref_rise;

  assign ref_rise = ref_s2_q & ~ref_prev_q;

  // divided copies advance on rising edges of the reference
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ref_prev_q <= 1'b0;
      div_q      <= 2'h0;
    end else begin
      ref_prev_q <= ref_s2_q;
      if (ref_rise) begin
        div_q <= div_q + 2'h1;
      end
    end
  end

  // pick direct, half or quarter rate for a selection code
  function orcm_clk_pick;
    input [1:0] sel;
    input       ref_lvl;
    input [1:0] div;
    begin
      case (sel)
        `ORCM_CLK_DIRECT: orcm_clk_pick = ref_lvl;
        `ORCM_CLK_DIV2:   orcm_clk_pick = div[0];
        `ORCM_CLK_DIV4:   orcm_clk_pick = div[1];
        default:          orcm_clk_pick = 1'b0;
      endcase
    end
  endfunction

  // over-range levels from the four detectors
  wire [3:0] ovr_lvl;
  wire [3:0] ovr_rise;

  // registered pin drivers; synchroniser delay keeps them clean levels
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ref_out_q <= 1'b0;
      out_c_q   <= 1'b0;
      out_d_q   <= 1'b0;
    end else begin
      ref_out_q <= clocks_on & ref_s2_q;                           // RULE_13 RULE_11
      if (clk_c_on) begin
        out_c_q <= orcm_clk_pick(sel_c, ref_s2_q, div_q);          // RULE_06
      end else begin
        out_c_q <= ovr_lvl[2];                                     // RULE_05
      end
      if (clk_d_on) begin
        out_d_q <= orcm_clk_pick(sel_d, ref_s2_q, div_q);          // RULE_08
      end else if (clk_c_on) begin
        out_d_q <= ovr_lvl[3];  // D stays status while only C carries a clock
      end else begin
        out_d_q <= ovr_lvl[3];                                     // RULE_05
      end
    end
  end

  // ---------------------------------------------------------------
  // over-range detectors
  // ---------------------------------------------------------------
  wire [4*`ORCM_SAMPLE_W-1:0] samples;
  wire [3:0]                  det_en;

  assign samples = {sample_d_i, sample_c_i, sample_b_i, sample_a_i};
  // C and D detectors only enabled in quad mode; all idle in power-down
  assign det_en  = {{2{quad_mode}}, 2'h3} & {4{~pd_s2_q}};         // RULE_03

  genvar ch;
  generate
    for (ch = 0; ch < 4; ch = ch + 1) begin : g_det
      orcm_pulse u_det (
        .clk_i       (clk_i),
        .resetn_i    (resetn_i),
        .enable_i    (det_en[ch]),
        .thresh_i    (thresh_q),
        .min_pulse_i (minpulse_q),
        .sample_i    (samples[ch*`ORCM_SAMPLE_W +: `ORCM_SAMPLE_W]),
        .level_o     (ovr_lvl[ch]),
        .rise_o      (ovr_rise[ch])
      );
    end
  endgenerate

  // power-down entry is an event too
  reg pd_prev_q;

  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pd_prev_q <= 1'b1;
    end else begin
      pd_prev_q <= pd_s2_q;
    end
  end

  assign irq_set = {pd_s2_q & ~pd_prev_q, ovr_rise};

  // ---------------------------------------------------------------
  // read port
  // ---------------------------------------------------------------
  // state word: pins seen, routing result and live levels
  always @* begin
    rdata_d = {`ORCM_DATA_W{1'b0}};
    case (reg_addr_i)
      `ORCM_OFF_CTRL:       rdata_d[`ORCM_CTRL_W-1:0]    = ctrl_q;
      `ORCM_OFF_THRESH:     rdata_d[`ORCM_SAMPLE_W-1:0]  = thresh_q;
      `ORCM_OFF_MINPULSE:   rdata_d[`ORCM_PULSE_W-1:0]   = minpulse_q;
      `ORCM_OFF_STATE:      rdata_d[11:0]                = {clk_d_on, clk_c_on, clocks_on,
                                                            pd_s2_q, pll_s2_q, cfg_s2_q,
                                                            1'b0, ovr_lvl};
      `ORCM_OFF_IRQ_STATUS: rdata_d[`ORCM_IRQ_W-1:0]     = irq_stat_q;
      `ORCM_OFF_IRQ_MASK:   rdata_d[`ORCM_IRQ_W-1:0]     = irq_mask_q;
      default:              rdata_d                      = {`ORCM_DATA_W{1'b0}};
    endcase
  end

  // data stand only in the cycle after the read strobe
  always @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rdata_q <= {`ORCM_DATA_W{1'b0}};
    end else if (reg_rd_i) begin
      rdata_q <= rdata_d;
    end else begin
      rdata_q <= {`ORCM_DATA_W{1'b0}};
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign reg_rdata_o                  = rdata_q;
  assign overrange_out_a_o            = ovr_lvl[0];                // RULE_01
  assign overrange_out_b_o            = ovr_lvl[1];
  assign overrange_or_clock_out_c_o   = out_c_q;
  assign overrange_or_clock_out_d_o   = out_d_q;
  assign reference_clock_repeat_out_o = ref_out_q;
  assign pll_active_o                 = clocks_on;                 // RULE_14
  assign pll_bypass_o                 = ~pll_s2_q;                 // RULE_14
  assign powered_down_o               = pd_s2_q;                   // RULE_11

endmodule

// ==== sim/orcm_chk.sv ====
`timescale 1ns/1ps
module orcm_chk (
  // clock and reset
  input logic        clk_i,
  input logic        resetn_i,
  // register port
  input logic [3:0]  reg_addr_i,
  input logic [15:0] reg_wdata_i,
  input logic        reg_wr_i,
  input logic        reg_rd_i,
  input logic [15:0] reg_rdata_o,
  // pins
  input logic [11:0] sample_a_i,
  input logic        overrange_out_a_o,
  input logic        overrange_or_clock_out_c_o,
  input logic        overrange_or_clock_out_d_o,
  input logic        reference_clock_repeat_out_o,
  input logic        pll_active_o,
  input logic        pll_bypass_o,
  input logic        powered_down_o
);
  logic [11:0] thr_q;
  logic [7:0]  mp_q;
  logic [7:0]  run_q;
  logic [7:0]  quiet_q;
  logic [7:0]  mp_eff;
  logic [12:0] mag;
  logic        over;
  // ----------------------------------------
  // shadow of settings and pulse counters
  // ----------------------------------------
  // magnitude needs 13 bits so the most negative sample is not folded to zero
  assign mag    = sample_a_i[11] ? 13'h1000 - {1'b0, sample_a_i} : {1'b0, sample_a_i};
  assign over   = mag > {1'b0, thr_q};
  assign mp_eff = (mp_q == 8'h00) ? 8'h01 : mp_q;
  // counters saturate so long pulses cannot wrap into false failures
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      thr_q   <= 12'h700;
      mp_q    <= 8'h08;
      run_q   <= 8'h00;
      quiet_q <= 8'hFF;
    end else begin
      if (reg_wr_i && reg_addr_i == 4'h1) thr_q <= reg_wdata_i[11:0];
      if (reg_wr_i && reg_addr_i == 4'h2) mp_q <= reg_wdata_i[7:0];
      run_q   <= !overrange_out_a_o ? 8'h00 : (run_q == 8'hFF) ? run_q : run_q + 8'h01;
      quiet_q <= over ? 8'h00 : (quiet_q == 8'hFF) ? quiet_q : quiet_q + 8'h01;
    end
  end
  // ----------------------------------------
  // properties
  // ----------------------------------------
  default clocking @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  // three samples cover sync, detector and output flop
  sequence pd_held_s;
    powered_down_o ##1 powered_down_o ##1 powered_down_o;
  endsequence
  pd_quiet_a: assert property (
    pd_held_s |-> !reference_clock_repeat_out_o && !overrange_or_clock_out_c_o
                  && !overrange_or_clock_out_d_o) else $error("outputs active in power-down");
  pd_off_a: assert property (powered_down_o |-> !pll_active_o)
    else $error("pll active in power-down");
  ref_gate_a: assert property (!$past(pll_active_o) |-> !reference_clock_repeat_out_o)
    else $error("reference repeat without enable");
  pll_bypass_a: assert property (pll_active_o |-> !pll_bypass_o)
    else $error("pll active and bypassed");
  ovr_rise_a: assert property (over && !powered_down_o |=> overrange_out_a_o)
    else $error("over-range A missed");
  min_pulse_a: assert property (
    $fell(overrange_out_a_o) && !powered_down_o && !$past(powered_down_o) |-> run_q >= mp_eff)
    else $error("over-range A pulse too short");
  ovr_fall_a: assert property (quiet_q >= mp_eff |-> !overrange_out_a_o)
    else $error("over-range A held too long");
  rdata_idle_a: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 16'h0000)
    else $error("read data outside read slot");
endmodule

bind orcm_top orcm_chk u_chk (
  .clk_i                        (clk_i),
  .resetn_i                     (resetn_i),
  .reg_addr_i                   (reg_addr_i),
  .reg_wdata_i                  (reg_wdata_i),
  .reg_wr_i                     (reg_wr_i),
  .reg_rd_i                     (reg_rd_i),
  .reg_rdata_o                  (reg_rdata_o),
  .sample_a_i                   (sample_a_i),
  .overrange_out_a_o            (overrange_out_a_o),
  .overrange_or_clock_out_c_o   (overrange_or_clock_out_c_o),
  .overrange_or_clock_out_d_o   (overrange_or_clock_out_d_o),
  .reference_clock_repeat_out_o (reference_clock_repeat_out_o),
  .pll_active_o                 (pll_active_o),
  .pll_bypass_o                 (pll_bypass_o),
  .powered_down_o               (powered_down_o)
);

// ==== sim/orcm_rx.sv ====
`timescale 1ns/1ps
module orcm_rx (
  // clock and window clear
  input  logic            clk_i,
  input  logic            clr_i,
  // received lines
  input  logic            ref_i,
  input  logic            a_i,
  input  logic            b_i,
  input  logic            c_i,
  input  logic            d_i,
  // counts: 0 ref, 1 a, 2 b, 3 c, 4 d
  output logic [4:0][7:0] rise_cnt_o,
  output logic [4:0][7:0] high_cnt_o
);
  logic [4:0] v;
  logic [4:0] v_q;
  assign v = {d_i, c_i, b_i, a_i, ref_i};
  // sampled like a receiving fpga: edges only count on the local clock
  always_ff @(posedge clk_i) begin
    v_q <= v;
    for (int i = 0; i < 5; i++) begin
      if (clr_i) begin
        rise_cnt_o[i] <= 8'h00;
        high_cnt_o[i] <= 8'h00;
      end else begin
        if (v[i] && !v_q[i]) rise_cnt_o[i] <= rise_cnt_o[i] + 8'h01;
        if (v[i]) high_cnt_o[i] <= high_cnt_o[i] + 8'h01;
      end
    end
  end
endmodule

// ==== sim/testbench.sv ====
`timescale 1ns/1ps
module testbench;
  logic            clk = 1'b0;
  logic            resetn, reg_wr, reg_rd, pll_en, pd, refc, clr;
  logic [3:0]      addr;
  logic [15:0]     wdata;
  logic [1:0]      cfg;
  logic [11:0]     sa, sb, sc, sd;
  wire  [15:0]     rdata;
  wire             ova, ovb, ovc, ovd, refo, act, byp, pdo, irq;
  wire  [4:0][7:0] rise;
  wire  [4:0][7:0] high;
  int              fails = 0;
  int              cmp_count = 0;

  orcm_top u_dut (.clk_i(clk), .resetn_i(resetn), .reg_addr_i(addr), .reg_wdata_i(wdata),
    .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_rdata_o(rdata), .sample_a_i(sa),
    .sample_b_i(sb), .sample_c_i(sc), .sample_d_i(sd), .aux_clock_config_pins_i(cfg),
    .pll_enable_i(pll_en), .power_down_in_i(pd), .ref_clock_in_i(refc),
    .overrange_out_a_o(ova), .overrange_out_b_o(ovb), .overrange_or_clock_out_c_o(ovc),
    .overrange_or_clock_out_d_o(ovd), .reference_clock_repeat_out_o(refo),
    .pll_active_o(act), .pll_bypass_o(byp), .powered_down_o(pdo), .irq_o(irq));
  orcm_rx u_rx (.clk_i(clk), .clr_i(clr), .ref_i(refo), .a_i(ova), .b_i(ovb), .c_i(ovc),
    .d_i(ovd), .rise_cnt_o(rise), .high_cnt_o(high));

  // ----------------------------------------
  // clocks: reference is eight system cycles long, slow enough for the pin sync
  // ----------------------------------------
  initial forever #4 clk = ~clk;
  initial begin
    refc = 1'b0;
    forever begin
      repeat (4) @(posedge clk);
      refc <= ~refc;
    end
  end

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task chk(input string n, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk); reg_wr <= 1'b1; addr <= a; wdata <= d;
    @(posedge clk); reg_wr <= 1'b0;
  endtask
  // read data stand only in the slot after the strobe, so look there
  task rd(input string n, input logic [3:0] a, input logic [15:0] e);
    @(posedge clk); reg_rd <= 1'b1; addr <= a;
    @(posedge clk); reg_rd <= 1'b0;
    #1 chk(n, rdata, e);
  endtask
  task pins(input logic [1:0] c, input logic e, input logic p);
    @(posedge clk); cfg <= c; pll_en <= e; pd <= p;
  endtask
  // a window of 64 cycles holds a whole number of periods of every divided clock
  task clocks(input logic [7:0] er, input logic [7:0] ec, input logic [7:0] ed);
    repeat (8) @(posedge clk); clr <= 1'b1;
    @(posedge clk); clr <= 1'b0;
    repeat (64) @(posedge clk);
    #1 chk("ref edges", {8'h00, rise[0]}, {8'h00, er});
    chk("c edges", {8'h00, rise[3]}, {8'h00, ec});
    chk("d edges", {8'h00, rise[4]}, {8'h00, ed});
  endtask
  task pulse(input logic [11:0] a, b, c, d);
    @(posedge clk); clr <= 1'b1;
    @(posedge clk); clr <= 1'b0; sa <= a; sb <= b; sc <= c; sd <= d;
    @(posedge clk); sa <= 12'h000; sb <= 12'h000; sc <= 12'h000; sd <= 12'h000;
    repeat (12) @(posedge clk);
    #1;
  endtask
  task summarize;
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    resetn = 1'b0; reg_wr = 1'b0; reg_rd = 1'b0; addr = 4'h0; wdata = 16'h0000; clr = 1'b0;
    cfg = 2'h0; pll_en = 1'b1; pd = 1'b0;
    sa = 12'h000; sb = 12'h000; sc = 12'h000; sd = 12'h000;
    repeat (20) @(posedge clk);
    resetn <= 1'b1;
    rd("ctrl", 4'h0, 16'h0001);
    rd("thresh", 4'h1, 16'h0700);
    rd("minpulse", 4'h2, 16'h0008);
    rd("mask", 4'h5, 16'h0000);
    rd("unmapped", 4'h6, 16'h0000);
    for (int k = 0; k < 4; k++) begin
      pins(k[1:0], 1'b1, 1'b0);
      clocks(8'h08, (k == 0) ? 8'h00 : 8'h08 >> (k - 1), (k == 0) ? 8'h00 : 8'h08);
    end
    wr(4'h0, 16'h0023);
    clocks(8'h08, 8'h00, 8'h00);
    wr(4'h0, 16'h0027);
    clocks(8'h08, 8'h08, 8'h04);
    chk("pll active", {15'h0000, act}, 16'h0001);
    rd("state", 4'h3, 16'h0EE0);
    wr(4'h0, 16'h0041);
    clocks(8'h08, 8'h00, 8'h00);
    wr(4'h0, 16'h0001);
    pins(2'h1, 1'b0, 1'b0);
    clocks(8'h00, 8'h00, 8'h00);
    chk("bypass", {15'h0000, byp}, 16'h0001);
    chk("pll inactive", {15'h0000, act}, 16'h0000);
    pins(2'h1, 1'b1, 1'b1);
    clocks(8'h00, 8'h00, 8'h00);
    chk("powered down", {15'h0000, pdo}, 16'h0001);
    chk("active in pd", {15'h0000, act}, 16'h0000);
    rd("status pd", 4'h4, 16'h0010);
    pins(2'h0, 1'b1, 1'b0);
    wr(4'h4, 16'h001F);
    wr(4'h2, 16'h0003);
    wr(4'h5, 16'h0001);
    pulse(12'h701, 12'h8FF, 12'h700, 12'h000);
    chk("a high", {8'h00, high[1]}, 16'h0003);
    chk("b high", {8'h00, high[2]}, 16'h0003);
    chk("c at threshold", {8'h00, high[3]}, 16'h0000);
    chk("irq", {15'h0000, irq}, 16'h0001);
    rd("status", 4'h4, 16'h0003);
    wr(4'h4, 16'h0001);
    rd("status cleared", 4'h4, 16'h0002);
    chk("irq cleared", {15'h0000, irq}, 16'h0000);
    wr(4'h0, 16'h0000);
    pulse(12'h000, 12'h000, 12'h7FF, 12'h801);
    chk("c not quad", {8'h00, high[3]}, 16'h0000);
    chk("d not quad", {8'h00, high[4]}, 16'h0000);
    wr(4'h0, 16'h0001);
    pulse(12'h000, 12'h000, 12'h7FF, 12'h801);
    chk("c quad", {8'h00, high[3]}, 16'h0003);
    chk("d quad", {8'h00, high[4]}, 16'h0003);
    summarize;
  end

  // watchdog well beyond the roughly 770 cycles of the sequence
  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    summarize;
  end
endmodule
